// ===== core/bil_pkg.sv
// Package of constants and types for the boot image loader.
package bil_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int RESET_PHASE_US = 15;
  localparam int RESET_PHASE_CYC = (RESET_PHASE_US * (CLK_HZ / 1000000) > 0) ?
    RESET_PHASE_US * (CLK_HZ / 1000000) : 1;
  localparam int LINK_EN_NS = 200;
  localparam int LINK_EN_CYC = (LINK_EN_NS * (CLK_HZ / 1000000) / 1000 > 0) ?
    LINK_EN_NS * (CLK_HZ / 1000000) / 1000 : 1;
  localparam int SPI_HZ = 2500000;
  localparam int SPI_HALF_CYC = (CLK_HZ / (2 * SPI_HZ) > 0) ? CLK_HZ / (2 * SPI_HZ) : 1;
  localparam logic [31:0] CRC_SKIP = 32'h0d15ab1e;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [7:0] SPI_READ_CMD = 8'h03;
  localparam logic [23:0] SPI_START_ADDR = 24'h000000;
  localparam logic [31:0] NULL_CHANEND = 32'h0000ff02;
  localparam logic [7:0] TOKEN_END = 8'h01;
  localparam int OTP_SECTORS = 4;
  localparam int OTP_ROWS = 512;
  localparam logic [15:0] OTP_ADDR_SEC = 16'h07ff;
  localparam logic [15:0] OTP_ADDR_IMG = 16'h0000;
  localparam logic [31:0] OTP_ADDR_PORT_ID = 32'h00100200;
  localparam logic [31:0] OTP_DATA_PORT_ID = 32'h00200100;
  localparam logic [31:0] OTP_CTRL_PORT_ID = 32'h00100300;
  localparam int SEC_NO_DEBUG = 0;
  localparam int SEC_NO_LINK = 1;
  localparam int SEC_SECURE_BOOT = 5;
  localparam int SEC_REDUNDANT = 7;
  localparam int SEC_LOCK0 = 8;
  localparam int SEC_MASTER_LOCK = 12;
  localparam int SEC_NO_DEBUG_OTP = 13;
  localparam int SEC_GP_LO = 15;
  localparam int SEC_GP_HI = 21;
  localparam int SEC_UID_LO = 22;
  localparam int SEC_UID_HI = 31;
  localparam logic [1:0] BOOT_SRC_LINK = 2'h0;
  localparam logic [1:0] BOOT_SRC_SPI = 2'h1;
  typedef enum {
    BIL_RESET, BIL_SEC_LOAD, BIL_SELECT, BIL_SPI_CMD, BIL_LINK_WAIT,
    BIL_LINK_ACK, BIL_IMG_LEN, BIL_IMG_BODY, BIL_IMG_CRC, BIL_LINK_END,
    BIL_LINK_REPLY, BIL_RUN, BIL_HALT
  } bil_state_e;
  typedef struct packed {
    logic no_debug;
    logic no_link_access;
    logic redundant_rows;
    logic [3:0] sector_lock;
    logic master_lock;
    logic no_debug_otp;
    logic [6:0] gp_field;
    logic [9:0] user_id;
  } bil_sec_s;
  typedef struct packed {
    logic o;
    logic oe;
  } bil_pin_s;
endpackage

// ===== core/bil_loader.sv
// Boot image loader: strap select, SPI/link/OTP image load, CRC check, security decode.
`timescale 1ns/1ps
module bil_loader #(
  parameter int RAM_AW = 14,
  parameter int OTP_AW = 11
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_rst_n_pin,
  input wire logic i_pll_locked,
  input wire logic [1:0] i_boot_strap,
  input wire logic i_clock_ratio_strap_low,
  input wire logic i_clock_ratio_strap_high,
  input wire logic i_boot_spi_miso_pin,
  output logic o_boot_spi_select_pin,
  output logic o_boot_spi_select_pin_oe,
  output logic o_boot_spi_clock_pin,
  output logic o_boot_spi_clock_pin_oe,
  output logic o_boot_spi_mosi_pin,
  output logic o_boot_spi_mosi_pin_oe,
  output logic o_link_tx_pin_a,
  output logic o_link_tx_pin_a_oe,
  output logic o_link_tx_pin_b,
  output logic o_link_tx_pin_b_oe,
  input wire logic i_link_rx_pin_a,
  input wire logic i_link_rx_pin_b,
  output logic o_link_pulldown_en,
  output logic o_gpio_pull_en,
  output logic o_gpio_hiz,
  output logic o_otp_rd,
  output logic [OTP_AW-1:0] o_otp_addr,
  input wire logic [31:0] i_otp_rdata,
  input wire logic i_otp_prog_req,
  input wire logic [15:0] i_otp_prog_addr,
  output logic o_otp_prog_ok,
  output logic o_ram_we,
  output logic [RAM_AW-1:0] o_ram_addr,
  output logic [31:0] o_ram_wdata,
  output logic o_run,
  output logic [RAM_AW-1:0] o_start_addr,
  output logic o_halted,
  output logic [31:0] o_security_config,
  output logic o_debug_block,
  output logic o_switch_block,
  output logic o_debug_otp_block,
  output logic o_redundant_rows,
  output logic [1:0] o_clock_ratio
);
  logic [1:0] rstn_sync_r;
  logic [1:0] miso_sync_r, rxa_sync_r, rxb_sync_r;
  logic [1:0] lock_sync_r, strap_sync0_r, strap_sync1_r;
  logic rxa_d_r, rxb_d_r;
  bil_pkg::bil_state_e state_r;
  logic [15:0] wait_r;
  logic [31:0] sec_r;
  logic [1:0] src_r;
  logic [31:0] shreg_r;
  logic [5:0] bitcnt_r;
  logic [1:0] bytecnt_r;
  logic [31:0] word_r;
  logic word_done;
  logic [31:0] len_r, cnt_r;
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;
  logic [7:0] byte_in;
  logic byte_done;
  logic [OTP_AW-1:0] otp_ptr_r;
  logic spi_active_r, sclk_r;
  logic [7:0] half_r;
  logic tx_bit;
  logic run_r, halt_r;
  logic txa_r, txb_r;
  logic [3:0] txbit_r;
  logic [7:0] token_r;
  bil_pkg::bil_sec_s sec_f;

  // Synchronisers for every pin input except the clock ratio straps.
  always_ff @(posedge i_clock) begin
    rstn_sync_r <= {rstn_sync_r[0], i_rst_n_pin};
    miso_sync_r <= {miso_sync_r[0], i_boot_spi_miso_pin};
    rxa_sync_r <= {rxa_sync_r[0], i_link_rx_pin_a};
    rxb_sync_r <= {rxb_sync_r[0], i_link_rx_pin_b};
    lock_sync_r <= {lock_sync_r[0], i_pll_locked};
    strap_sync0_r <= i_boot_strap;
    strap_sync1_r <= strap_sync0_r;
    rxa_d_r <= rxa_sync_r[1];
    rxb_d_r <= rxb_sync_r[1];
  end

  always_comb begin
    crc_nxt = crc_r ^ {24'h000000, byte_in};
    for (int k = 0; k < 8; k++) begin
      crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ bil_pkg::CRC_POLY) : (crc_nxt >> 1);
    end
  end

  // serial bytes arrive LSB first, so shift in from the top.
  logic spi_sample;
  // The synchroniser lags the pin by two cycles, so the value seen at the falling
  // edge is the one the pin held at the rising edge, as mode 0 wants.
  assign spi_sample = spi_active_r && sclk_r && (half_r == 8'(bil_pkg::SPI_HALF_CYC - 1));
  // Link bits are data strobe style: a one on line b, a zero on line a.
  logic link_bit_ev, link_bit_val;
  assign link_bit_ev = (rxa_sync_r[1] != rxa_d_r) || (rxb_sync_r[1] != rxb_d_r);
  assign link_bit_val = rxb_sync_r[1] != rxb_d_r;
  logic bit_ev, bit_val, rx_phase;
  assign rx_phase = (state_r == bil_pkg::BIL_LINK_ACK) || (state_r == bil_pkg::BIL_IMG_LEN) ||
    (state_r == bil_pkg::BIL_IMG_BODY) || (state_r == bil_pkg::BIL_IMG_CRC) ||
    (state_r == bil_pkg::BIL_LINK_END);
  assign bit_ev = rx_phase && (src_r == bil_pkg::BOOT_SRC_SPI ? spi_sample : link_bit_ev);
  assign bit_val = src_r == bil_pkg::BOOT_SRC_SPI ? miso_sync_r[1] : link_bit_val;
  assign byte_done = bit_ev && (bitcnt_r[2:0] == 3'h7);
  assign byte_in = {bit_val, shreg_r[31:25]};
  // four bytes form a word, least significant byte first.
  assign word_done = byte_done && (bytecnt_r == 2'h3);

  always_ff @(posedge i_clock) begin
    if (i_rst || state_r == bil_pkg::BIL_SELECT) begin
      shreg_r <= 32'h00000000;
      bitcnt_r <= 6'h00;
      bytecnt_r <= 2'h0;
    end else if (bit_ev) begin
      shreg_r <= {bit_val, shreg_r[31:1]};
      bitcnt_r <= bitcnt_r + 6'h01;
      if (byte_done) begin
        bytecnt_r <= bytecnt_r + 2'h1;
      end
    end
  end
  assign word_r = {bit_val, shreg_r[31:1]};

  // SPI clock divider, mode 0 idles low.
  always_ff @(posedge i_clock) begin
    if (i_rst || !spi_active_r) begin
      half_r <= 8'h00;
      sclk_r <= 1'b0;
    end else if (half_r == 8'(bil_pkg::SPI_HALF_CYC - 1)) begin
      half_r <= 8'h00;
      sclk_r <= !sclk_r;
    end else begin
      half_r <= half_r + 8'h01;
    end
  end

  // read command then 24-bit zero address, shifted out LSB first.
  logic [31:0] cmd_word;
  assign cmd_word = {bil_pkg::SPI_START_ADDR, bil_pkg::SPI_READ_CMD};
  logic [5:0] txcnt_r;
  assign tx_bit = cmd_word[txcnt_r[4:0]];

  // end token out, one toggle per bit.
  always_ff @(posedge i_clock) begin
    if (i_rst || !rstn_sync_r[1]) begin
      txa_r <= 1'b0;
      txb_r <= 1'b0;
      txbit_r <= 4'h0;
    end else if (state_r == bil_pkg::BIL_LINK_REPLY && token_r != 8'h00 && !txbit_r[3]) begin
      txbit_r <= txbit_r + 4'h1;
      if (token_r[txbit_r[2:0]]) begin
        txb_r <= !txb_r;
      end else begin
        txa_r <= !txa_r;
      end
    end
  end

  // Main sequencer.
  always_ff @(posedge i_clock) begin
    if (i_rst || !rstn_sync_r[1]) begin
      state_r <= bil_pkg::BIL_RESET;
      wait_r <= 16'h0000;
      sec_r <= 32'h00000000;
      src_r <= 2'h0;
      len_r <= 32'h00000000;
      cnt_r <= 32'h00000000;
      crc_r <= bil_pkg::CRC_INIT;
      otp_ptr_r <= '0;
      spi_active_r <= 1'b0;
      txcnt_r <= 6'h00;
      run_r <= 1'b0;
      halt_r <= 1'b0;
      token_r <= 8'h00;
      o_ram_we <= 1'b0;
      o_ram_addr <= '0;
      o_ram_wdata <= 32'h00000000;
    end else begin
      o_ram_we <= 1'b0;
      case (state_r)
        // wait for lock, then the reset phase.
        bil_pkg::BIL_RESET: begin
          if (lock_sync_r[1]) begin
            wait_r <= wait_r + 16'h0001;
            if (wait_r == 16'(bil_pkg::RESET_PHASE_CYC - 1)) begin
              wait_r <= 16'h0000;
              state_r <= bil_pkg::BIL_SEC_LOAD;
            end
          end
        end
        // security word read first from the OTP.
        bil_pkg::BIL_SEC_LOAD: begin
          wait_r <= wait_r + 16'h0001;
          if (wait_r == 16'h0001) begin
            sec_r <= i_otp_rdata;
            wait_r <= 16'h0000;
            state_r <= bil_pkg::BIL_SELECT;
          end
        end
        bil_pkg::BIL_SELECT: begin
          crc_r <= bil_pkg::CRC_INIT;
          cnt_r <= 32'h00000000;
          otp_ptr_r <= OTP_AW'(bil_pkg::OTP_ADDR_IMG);
          if (sec_r[bil_pkg::SEC_SECURE_BOOT]) begin
            src_r <= 2'h2;
            state_r <= bil_pkg::BIL_IMG_LEN;
          end else if (strap_sync1_r == bil_pkg::BOOT_SRC_SPI) begin
            src_r <= bil_pkg::BOOT_SRC_SPI;
            spi_active_r <= 1'b1;
            state_r <= bil_pkg::BIL_SPI_CMD;
          end else begin
            src_r <= bil_pkg::BOOT_SRC_LINK;
            state_r <= bil_pkg::BIL_LINK_WAIT;
          end
        end
        bil_pkg::BIL_SPI_CMD: begin
          if (sclk_r && half_r == 8'(bil_pkg::SPI_HALF_CYC - 1)) begin
            txcnt_r <= txcnt_r + 6'h01;
            if (txcnt_r == 6'h1f) begin
              state_r <= bil_pkg::BIL_IMG_LEN;
            end
          end
        end
        // link enabled after the fixed delay.
        bil_pkg::BIL_LINK_WAIT: begin
          wait_r <= wait_r + 16'h0001;
          if (wait_r == 16'(bil_pkg::LINK_EN_CYC - 1)) begin
            wait_r <= 16'h0000;
            state_r <= bil_pkg::BIL_LINK_ACK;
          end
        end
        // acknowledge channel word, not part of the image.
        bil_pkg::BIL_LINK_ACK: begin
          if (word_done) begin
            token_r <= (word_r == bil_pkg::NULL_CHANEND) ? 8'h00 : bil_pkg::TOKEN_END;
            state_r <= bil_pkg::BIL_IMG_LEN;
          end
        end
        // length word comes first and enters the CRC.
        bil_pkg::BIL_IMG_LEN: begin
          if (src_r == 2'h2) begin
            len_r <= i_otp_rdata;
            crc_r <= bil_crc_word(crc_r, i_otp_rdata);
            otp_ptr_r <= otp_ptr_r + 1'b1;
            state_r <= (i_otp_rdata == 32'h0) ? bil_pkg::BIL_IMG_CRC : bil_pkg::BIL_IMG_BODY;
          end else begin
            if (byte_done) begin
              crc_r <= crc_nxt;
            end
            if (word_done) begin
              len_r <= word_r;
              state_r <= (word_r == 32'h0) ? bil_pkg::BIL_IMG_CRC : bil_pkg::BIL_IMG_BODY;
            end
          end
        end
        // program words land from RAM address zero upward.
        bil_pkg::BIL_IMG_BODY: begin
          if (src_r == 2'h2) begin
            o_ram_we <= 1'b1;
            o_ram_wdata <= i_otp_rdata;
            o_ram_addr <= RAM_AW'(cnt_r);
            crc_r <= bil_crc_word(crc_r, i_otp_rdata);
            otp_ptr_r <= otp_ptr_r + 1'b1;
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r + 32'h1 == len_r) begin
              state_r <= bil_pkg::BIL_IMG_CRC;
            end
          end else begin
            if (byte_done) begin
              crc_r <= crc_nxt;
            end
            if (word_done) begin
              o_ram_we <= 1'b1;
              o_ram_wdata <= word_r;
              o_ram_addr <= RAM_AW'(cnt_r);
              cnt_r <= cnt_r + 32'h1;
              if (cnt_r + 32'h1 == len_r) begin
                state_r <= bil_pkg::BIL_IMG_CRC;
              end
            end
          end
        end
        // mismatch halts unless the skip value was sent.
        bil_pkg::BIL_IMG_CRC: begin
          if (src_r == 2'h2 || word_done) begin
            if ((src_r == 2'h2 ? i_otp_rdata : word_r) != bil_pkg::CRC_SKIP &&
                (src_r == 2'h2 ? i_otp_rdata : word_r) != ~crc_r) begin
              halt_r <= 1'b1;
              spi_active_r <= 1'b0;
              state_r <= bil_pkg::BIL_HALT;
            end else if (src_r == bil_pkg::BOOT_SRC_LINK) begin
              state_r <= bil_pkg::BIL_LINK_END;
            end else begin
              spi_active_r <= 1'b0;
              state_r <= bil_pkg::BIL_RUN;
            end
          end
        end
        // end token in, end token out unless the ack word was the null chanend, then run.
        bil_pkg::BIL_LINK_END: begin
          if (byte_done && byte_in == bil_pkg::TOKEN_END) begin
            state_r <= bil_pkg::BIL_LINK_REPLY;
          end
        end
        bil_pkg::BIL_LINK_REPLY: begin
          if (token_r == 8'h00 || txbit_r[3]) begin
            state_r <= bil_pkg::BIL_RUN;
          end
        end
        bil_pkg::BIL_RUN: begin
          run_r <= 1'b1;
        end
        bil_pkg::BIL_HALT: begin
          halt_r <= 1'b1;
        end
        default: state_r <= bil_pkg::BIL_RESET;
      endcase
    end
  end

  function automatic logic [31:0] bil_crc_word(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    r = c;
    for (int k = 0; k < 32; k++) begin
      r = (r[0] ^ w[k]) ? ((r >> 1) ^ bil_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // OTP row address; security word sits in the top row.
  assign o_otp_rd = (state_r == bil_pkg::BIL_SEC_LOAD) || (src_r == 2'h2 && rx_phase);
  assign o_otp_addr = (state_r == bil_pkg::BIL_SEC_LOAD) ? OTP_AW'(bil_pkg::OTP_ADDR_SEC) :
    otp_ptr_r;

  // access gates decoded from security word.
  assign sec_f.no_debug = sec_r[bil_pkg::SEC_NO_DEBUG];
  assign sec_f.no_link_access = sec_r[bil_pkg::SEC_NO_LINK];
  assign sec_f.redundant_rows = sec_r[bil_pkg::SEC_REDUNDANT];
  assign sec_f.sector_lock = sec_r[bil_pkg::SEC_LOCK0 +: bil_pkg::OTP_SECTORS];
  // master lock and debug OTP block.
  assign sec_f.master_lock = sec_r[bil_pkg::SEC_MASTER_LOCK];
  assign sec_f.no_debug_otp = sec_r[bil_pkg::SEC_NO_DEBUG_OTP];
  assign sec_f.gp_field = sec_r[bil_pkg::SEC_GP_HI:bil_pkg::SEC_GP_LO];
  assign sec_f.user_id = sec_r[bil_pkg::SEC_UID_HI:bil_pkg::SEC_UID_LO];

  // programming allowed only where no lock covers the target.
  logic [1:0] prog_sector;
  assign prog_sector = 2'(i_otp_prog_addr[15:0] / 16'(bil_pkg::OTP_ROWS));
  assign o_otp_prog_ok = i_otp_prog_req && !sec_f.master_lock &&
    !sec_f.sector_lock[prog_sector] && (state_r == bil_pkg::BIL_RUN);

  assign o_security_config = sec_r;
  assign o_debug_block = sec_f.no_debug;
  assign o_switch_block = sec_f.no_link_access;
  assign o_debug_otp_block = sec_f.no_debug_otp;
  assign o_redundant_rows = sec_f.redundant_rows;
  assign o_clock_ratio = {i_clock_ratio_strap_high, i_clock_ratio_strap_low};

  // pins released while reset is held.
  assign o_gpio_hiz = (state_r == bil_pkg::BIL_RESET);
  assign o_gpio_pull_en = !o_gpio_hiz;
  assign o_boot_spi_select_pin = !(spi_active_r);
  assign o_boot_spi_select_pin_oe = (src_r == bil_pkg::BOOT_SRC_SPI) && !o_gpio_hiz;
  assign o_boot_spi_clock_pin = sclk_r;
  assign o_boot_spi_clock_pin_oe = o_boot_spi_select_pin_oe;
  assign o_boot_spi_mosi_pin = (state_r == bil_pkg::BIL_SPI_CMD) ? tx_bit : 1'b0;
  assign o_boot_spi_mosi_pin_oe = o_boot_spi_select_pin_oe;

  // link pins driven low, pull-downs off once enabled.
  logic link_on;
  assign link_on = src_r == bil_pkg::BOOT_SRC_LINK && rx_phase ||
    state_r == bil_pkg::BIL_LINK_REPLY;
  assign o_link_pulldown_en = !link_on;
  // Both lines rest low; a reply token moves them by toggles, as on receive.
  assign o_link_tx_pin_a = txa_r;
  assign o_link_tx_pin_b = txb_r;
  assign o_link_tx_pin_a_oe = link_on;
  assign o_link_tx_pin_b_oe = link_on;

  assign o_run = run_r;
  assign o_start_addr = '0;
  assign o_halted = halt_r;
endmodule

// ===== verif/bil_loader_asserts.sv
// Concurrent checks on the boot image loader ports.
`timescale 1ns/1ps
module bil_loader_asserts #(
  parameter int RAM_AW = 14,
  parameter int OTP_AW = 11
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_rst_n_pin,
  input wire logic o_boot_spi_select_pin,
  input wire logic o_boot_spi_select_pin_oe,
  input wire logic o_boot_spi_clock_pin,
  input wire logic o_boot_spi_mosi_pin,
  input wire logic o_link_tx_pin_a_oe,
  input wire logic o_link_tx_pin_b,
  input wire logic o_link_pulldown_en,
  input wire logic o_gpio_hiz,
  input wire logic i_otp_prog_req,
  input wire logic [15:0] i_otp_prog_addr,
  input wire logic o_otp_prog_ok,
  input wire logic o_ram_we,
  input wire logic o_run,
  input wire logic [RAM_AW-1:0] o_start_addr,
  input wire logic o_halted,
  input wire logic [31:0] o_security_config,
  input wire logic o_debug_block,
  input wire logic o_switch_block,
  input wire logic o_debug_otp_block,
  input wire logic o_redundant_rows
);
  default clocking cb @(posedge i_clock); endclocking
  // The pin reset is synchronised, so both resets silence every check but hiz_reset_a.
  default disable iff (i_rst || !i_rst_n_pin);
  hiz_reset_a:
    assert property (disable iff (i_rst) !i_rst_n_pin [*4] |-> o_gpio_hiz)
    else $error("pins driven during pin reset");
  start_zero_a:
    assert property (o_start_addr == '0) else $error("start address not zero");
  run_holds_a:
    assert property (o_run |=> o_run) else $error("run dropped");
  halt_holds_a:
    assert property (o_halted |=> o_halted && !o_run) else $error("halt left or ran");
  load_first_a:
    assert property (o_ram_we |-> !o_run) else $error("write after start");
  sclk_idle_a:
    assert property (o_boot_spi_select_pin_oe && o_boot_spi_select_pin |-> !o_boot_spi_clock_pin)
    else $error("serial clock not idle low");
  sclk_rate_a:
    assert property ($rose(o_boot_spi_clock_pin) |=> o_boot_spi_clock_pin ##1 !o_boot_spi_clock_pin)
    else $error("serial clock high phase wrong");
  mosi_hold_a:
    assert property ($changed(o_boot_spi_mosi_pin) && o_boot_spi_select_pin_oe
      && !o_boot_spi_select_pin |-> !o_boot_spi_clock_pin) else $error("data moved on high clock");
  link_idle_a:
    assert property (o_link_tx_pin_a_oe |-> !o_link_pulldown_en) else $error("pull-down on link");
  prog_lock_a:
    assert property (i_otp_prog_req && (o_security_config[12]
      || o_security_config[8 + i_otp_prog_addr[10:9]]) |-> !o_otp_prog_ok)
    else $error("locked sector programmable");
  sec_decode_a:
    assert property (o_debug_block == o_security_config[0] && o_switch_block == o_security_config[1]
      && o_debug_otp_block == o_security_config[13] && o_redundant_rows == o_security_config[7])
    else $error("security decode wrong");
  cover property (o_run);
  cover property (o_halted);
  cover property ($rose(o_link_tx_pin_b));
endmodule
bind bil_loader bil_loader_asserts #(.RAM_AW(RAM_AW), .OTP_AW(OTP_AW)) chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_rst_n_pin(i_rst_n_pin),
  .o_boot_spi_select_pin(o_boot_spi_select_pin), .o_boot_spi_select_pin_oe(o_boot_spi_select_pin_oe),
  .o_boot_spi_clock_pin(o_boot_spi_clock_pin), .o_boot_spi_mosi_pin(o_boot_spi_mosi_pin),
  .o_link_tx_pin_a_oe(o_link_tx_pin_a_oe), .o_link_tx_pin_b(o_link_tx_pin_b),
  .o_link_pulldown_en(o_link_pulldown_en), .o_gpio_hiz(o_gpio_hiz),
  .i_otp_prog_req(i_otp_prog_req), .i_otp_prog_addr(i_otp_prog_addr),
  .o_otp_prog_ok(o_otp_prog_ok), .o_ram_we(o_ram_we), .o_run(o_run),
  .o_start_addr(o_start_addr), .o_halted(o_halted), .o_security_config(o_security_config),
  .o_debug_block(o_debug_block), .o_switch_block(o_switch_block),
  .o_debug_otp_block(o_debug_otp_block), .o_redundant_rows(o_redundant_rows));

// ===== verif/bil_flash_model.sv
// Behavioural serial flash that answers the boot read.
`timescale 1ns/1ps
module bil_flash_model (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic [31:0] o_hdr
);
  logic [7:0] mem [0:63];
  logic bit_r = 1'b0;
  int cnt = 0;
  // header capture; a raised select restarts the count.
  always @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt = 0;
    end else begin
      if (cnt < 32) o_hdr[cnt] = i_mosi;
      cnt = cnt + 1;
    end
  end
  always @(negedge i_sclk) begin
    if (!i_cs_n && cnt >= 32) bit_r = mem[(cnt - 32) / 8][(cnt - 32) % 8];
  end
  // A released line shows the opposite of the last bit, so a stale copy is never trusted.
  assign o_miso = i_cs_n ? ~bit_r : bit_r;
endmodule

// ===== verif/testbench.sv
// Self-checking testbench for the boot image loader.
`timescale 1ns/1ps
module testbench;
  logic i_clock = 0;
  logic i_rst = 1;
  logic i_rst_n_pin = 0;
  logic i_pll_locked = 0;
  logic [1:0] i_boot_strap = 0;
  logic rlo = 0, rhi = 1, rxa = 0, rxb = 0, prog_req = 0;
  logic [15:0] prog_addr = 0;
  logic miso, cs, cs_oe, sck, mosi, txa, txa_oe, txb, pd_en, pull_en, hiz, ram_we, run;
  logic halted, prog_ok, dbg_b, sw_b, dotp_b, red, txa_q, txb_q, done, otp_rd;
  logic [10:0] otp_addr;
  logic [13:0] ram_addr, start_addr;
  logic [31:0] ram_wdata, sec, hdr;
  logic [1:0] ratio;
  logic [31:0] otp [0:2047];
  logic [31:0] ram [0:63];
  logic [7:0] img [$];
  int err_count = 0, check_count = 0, nwr = 0, nwr0 = 0, ntxa = 0, ntxb = 0;
  assign done = run | halted;
  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    if (ram_we) ram[ram_addr[5:0]] <= ram_wdata;
    nwr <= nwr + ram_we;
    ntxa <= ntxa + (txa !== txa_q);
    ntxb <= ntxb + (txb !== txb_q);
    txa_q <= txa;
    txb_q <= txb;
  end
  bil_loader dut (.i_clock(i_clock), .i_rst(i_rst), .i_rst_n_pin(i_rst_n_pin),
    .i_pll_locked(i_pll_locked), .i_boot_strap(i_boot_strap), .i_clock_ratio_strap_low(rlo),
    .i_clock_ratio_strap_high(rhi), .i_boot_spi_miso_pin(miso), .o_boot_spi_select_pin(cs),
    .o_boot_spi_select_pin_oe(cs_oe), .o_boot_spi_clock_pin(sck), .o_boot_spi_clock_pin_oe(),
    .o_boot_spi_mosi_pin(mosi), .o_boot_spi_mosi_pin_oe(), .o_link_tx_pin_a(txa),
    .o_link_tx_pin_a_oe(txa_oe), .o_link_tx_pin_b(txb), .o_link_tx_pin_b_oe(),
    .i_link_rx_pin_a(rxa), .i_link_rx_pin_b(rxb), .o_link_pulldown_en(pd_en),
    .o_gpio_pull_en(pull_en), .o_gpio_hiz(hiz), .o_otp_rd(otp_rd), .o_otp_addr(otp_addr),
    .i_otp_rdata(otp[otp_addr]), .i_otp_prog_req(prog_req), .i_otp_prog_addr(prog_addr),
    .o_otp_prog_ok(prog_ok), .o_ram_we(ram_we), .o_ram_addr(ram_addr), .o_ram_wdata(ram_wdata),
    .o_run(run), .o_start_addr(start_addr), .o_halted(halted), .o_security_config(sec),
    .o_debug_block(dbg_b), .o_switch_block(sw_b), .o_debug_otp_block(dotp_b),
    .o_redundant_rows(red), .o_clock_ratio(ratio));
  bil_flash_model flash (.i_sclk(sck), .i_cs_n(cs_oe ? cs : 1'b1), .i_mosi(mosi),
    .o_miso(miso), .o_hdr(hdr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_hi(ref logic s, input int max);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge i_clock);
      n++;
      if (n > max) begin
        check(0, 1);
        wrap_up();
      end
    end
  endtask
  function automatic logic [31:0] word(input int i);
    return 32'ha5c3_0f00 ^ (32'(i) * 32'h0102_0304);
  endfunction
  function automatic logic [31:0] crc32(input logic [7:0] q [$]);
    logic [31:0] c;
    c = bil_pkg::CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ bil_pkg::CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic put_w(input logic [31:0] w);
    for (int b = 0; b < 4; b++) img.push_back(w[8*b +: 8]);
  endtask
  // Mode 0 builds a good image, 1 a corrupted check word, 2 the skip value.
  task automatic make_img(input int n, input int mode);
    logic [31:0] c;
    img = {};
    for (int i = 0; i <= n; i++) put_w(i == 0 ? 32'(n) : word(i - 1));
    c = crc32(img) ^ 32'(mode == 1);
    put_w(mode == 2 ? bil_pkg::CRC_SKIP : c);
  endtask
  task automatic boot(input logic [1:0] src, input logic [31:0] sec_word);
    i_rst = 1;
    i_rst_n_pin = 0;
    i_pll_locked = 0;
    i_boot_strap = src;
    otp[11'(bil_pkg::OTP_ADDR_SEC)] = sec_word;
    foreach (ram[i]) ram[i] = 'x;
    repeat (5) @(negedge i_clock);
    i_rst = 0;
    repeat (5) @(negedge i_clock);
    check(hiz, 1);
    check(ratio, 2'b10);
    i_rst_n_pin = 1;
    repeat (20) @(negedge i_clock);
    check(pull_en, 0);
    i_pll_locked = 1;
    repeat (140) @(negedge i_clock);
    check(pull_en, 0);
    nwr0 = nwr;
    wait_hi(pull_en, 30);
    check({otp_rd, otp_addr}, {1'b1, 11'(bil_pkg::OTP_ADDR_SEC)});
  endtask
  task automatic check_run(input int n);
    wait_hi(done, 4000);
    check(run, 1);
    check(halted, 0);
    check(start_addr, 0);
    check(nwr - nwr0, n);
    for (int i = 0; i < n; i++) begin
      check(ram[i], word(i));
    end
  endtask
  task automatic spi_boot(input int mode);
    make_img(3, mode);
    foreach (img[i]) flash.mem[i] = img[i];
    boot(bil_pkg::BOOT_SRC_SPI, 0);
    wait_hi(done, 4000);
    check(hdr, {bil_pkg::SPI_START_ADDR, bil_pkg::SPI_READ_CMD});
    if (mode == 1) begin
      check({run, halted}, 2'b01);
    end else begin
      check_run(3);
    end
  endtask
  // Straps ask for serial boot; the security word must override them.
  task automatic otp_boot;
    logic [31:0] s;
    s = 32'hffc0_2221;
    make_img(2, 2);
    for (int i = 0; i < img.size() / 4; i++) begin
      otp[i] = {img[4*i+3], img[4*i+2], img[4*i+1], img[4*i]};
    end
    boot(bil_pkg::BOOT_SRC_SPI, s);
    check_run(2);
    check(sec, s);
    check({red, dotp_b, sw_b, dbg_b}, 4'b0101);
    prog_req = 1;
    prog_addr = 16'h0200;
    @(negedge i_clock);
    check(prog_ok, 0);
    prog_addr = 16'h0000;
    @(negedge i_clock);
    check(prog_ok, 1);
    prog_req = 0;
    for (int i = 0; i < 16; i++) otp[i] = 0;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int k = 0; k < 8; k++) begin
      if (b[k]) rxb = ~rxb;
      else rxa = ~rxa;
      repeat (8) @(negedge i_clock);
    end
  endtask
  task automatic link_boot(input logic [31:0] ack);
    logic [7:0] q [$];
    logic [7:0] e;
    int a0, b0;
    make_img(3, 0);
    q = {ack[7:0], ack[15:8], ack[23:16], ack[31:24], img, bil_pkg::TOKEN_END};
    e = (ack == bil_pkg::NULL_CHANEND) ? 8'h00 :
      {4'($countones(bil_pkg::TOKEN_END)), 4'(8 - $countones(bil_pkg::TOKEN_END))};
    // receive lines held low by the host.
    rxa = 0;
    rxb = 0;
    boot(bil_pkg::BOOT_SRC_LINK, 0);
    wait_hi(txa_oe, 10);
    check({txa, txb, pd_en}, 0);
    a0 = ntxa;
    b0 = ntxb;
    foreach (q[i]) send_byte(q[i]);
    check_run(3);
    check({4'(ntxb - b0), 4'(ntxa - a0)}, e);
  endtask
  initial begin
    foreach (otp[i]) otp[i] = 0;
    spi_boot(0);
    spi_boot(1);
    otp_boot();
    link_boot(32'h0003_0102);
    link_boot(bil_pkg::NULL_CHANEND);
    wrap_up();
  end
endmodule
